/* File: design/pdpm_pkg.sv */
// package: shared types and constants for the power state and thermal manager
package pdpm_pkg;

  // power states
  typedef enum logic [1:0] {
    PDPM_ACTIVE,
    PDPM_IDLE,
    PDPM_SLEEP
  } pdpm_state_e;

  // boot configuration phases
  typedef enum logic [1:0] {
    PDPM_BOOT_EEPROM,
    PDPM_BOOT_WAIT_HOST,
    PDPM_BOOT_DONE
  } pdpm_boot_e;

  // width of the inactivity counter and temperature codes
  localparam int unsigned PDPM_CNT_W  = 16;
  localparam int unsigned PDPM_TEMP_W = 8;

  // fixed eeprom target address
  localparam logic [6:0] PDPM_EEPROM_ADDR = 7'h50;

  // counter reset value and increment
  localparam logic [PDPM_CNT_W-1:0] PDPM_CNT_ZERO = 16'h0000;
  localparam logic [PDPM_CNT_W-1:0] PDPM_CNT_ONE  = 16'h0001;

  // activity sources that restart the quiet interval
  typedef struct packed {
    logic pd_msg;     // incoming pd message
    logic cc_change;  // cc status change
    logic gpio_evt;   // gpio input event
    logic i2c_xact;   // host i2c transaction
    logic volt_alert; // voltage alert
    logic fault_alert;// fault alert
  } pdpm_activity_s;

  // host configuration
  typedef struct packed {
    logic [PDPM_CNT_W-1:0]  idle_interval;     // quiet cycles before idle
    logic                   standby_en;        // idle runs as standby
    logic                   sleep_req;         // request sleep from idle
    logic                   path_auto_resume;  // resume paths on their own
    logic                   path_fw_reenable;  // firmware re-enable pulse
    logic                   sourcing;          // role: source when high
    logic                   sinking;           // role: sink when high
    logic [PDPM_TEMP_W-1:0] die_shutdown_threshold;
    logic [PDPM_TEMP_W-1:0] die_shutdown_hysteresis;
    logic [PDPM_TEMP_W-1:0] path_shutdown_threshold;
    logic [PDPM_TEMP_W-1:0] path_shutdown_hysteresis;
  } pdpm_cfg_s;

  // switch enables toward the power paths
  typedef struct packed {
    logic port_a_source_switch;
    logic port_b_source_switch;
    logic port_a_sink_gate_driver;
    logic port_b_sink_gate_driver;
    logic port_a_cable_supply_switch;
    logic port_b_cable_supply_switch;
  } pdpm_switch_s;

  localparam pdpm_switch_s PDPM_SW_OFF = '0;

endpackage : pdpm_pkg

/* File: design/pdpm_thermal_trip.sv */
// module: one hysteretic thermal trip with optional latch until firmware clears
`timescale 1ns/10ps
`default_nettype none
module pdpm_thermal_trip
  import pdpm_pkg::*;
(
  input  wire logic                   ref_clk_i,   // clock
  input  wire logic                   srst_i,      // sync reset, high
  input  wire logic                   ce_i,        // clock enable
  input  wire logic [PDPM_TEMP_W-1:0] temp_i,      // measured temperature
  input  wire logic [PDPM_TEMP_W-1:0] thresh_i,    // rising trip point
  input  wire logic [PDPM_TEMP_W-1:0] hyst_i,      // falling margin
  input  wire logic                   auto_i,      // resume on cooling
  input  wire logic                   reenable_i,  // firmware re-enable
  output logic                        trip_o       // shutdown active
);
  logic trip_reg;   // tripped
  logic cooled;     // below threshold minus hysteresis
  logic hot;        // above threshold
  logic trip_next;  // next trip value

  // falling point clamps at zero so a large margin cannot wrap
  assign hot    = temp_i > thresh_i;
  assign cooled = (thresh_i < hyst_i) ? 1'b0 : (temp_i < (thresh_i - hyst_i));
  // set wins over any clear in the same cycle
  assign trip_next = hot ? 1'b1 :
                     (trip_reg && cooled && (auto_i || reenable_i)) ? 1'b0 : trip_reg;

  // trip flop
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      trip_reg <= 1'b0;
    end else if (ce_i) begin
      trip_reg <= trip_next;
    end
  end

  assign trip_o = trip_reg;
endmodule : pdpm_thermal_trip
`default_nettype wire

/* File: design/pdpm_manager.sv */
// module: power state, switch gating, thermal shutdown and boot sequencing
`timescale 1ns/10ps
`default_nettype none
module pdpm_manager (
  input  wire logic                           ref_clk_i,         // 10 mhz clock
  input  wire logic                           srst_i,            // sync reset, high
  input  wire logic                           ce_i,              // clock enable
  input  wire pdpm_pkg::pdpm_activity_s       activity_i,        // same-domain activity pulses
  input  wire logic                           cc_attach_i,       // cc attach detect pin
  input  wire pdpm_pkg::pdpm_cfg_s            cfg_i,             // host configuration
  input  wire logic [pdpm_pkg::PDPM_TEMP_W-1:0] die_temp_i,      // die temperature code
  input  wire logic [pdpm_pkg::PDPM_TEMP_W-1:0] path_a_temp_i,   // port a path temperature
  input  wire logic [pdpm_pkg::PDPM_TEMP_W-1:0] path_b_temp_i,   // port b path temperature
  input  wire logic                           eeprom_done_i,     // eeprom fetch finished ok
  input  wire logic                           eeprom_nack_i,     // eeprom did not answer
  input  wire logic                           host_load_done_i,  // host loaded the bundle
  output logic                                eeprom_fetch_o,    // start eeprom master fetch
  output logic [6:0]                          eeprom_addr_o,     // eeprom target address
  output logic                                config_loaded_o,   // configuration present
  output logic                                waiting_host_o,    // waiting on host load
  output logic [1:0]                          power_state_o,     // active/idle/sleep code
  output logic                                standby_o,         // idle runs as standby
  output logic                                cc_monitor_en_o,   // cc detection enabled
  output logic                                functions_en_o,    // non-supervisory logic on
  output logic                                die_shutdown_o,    // die thermal shutdown
  output logic                                path_shutdown_o,   // path thermal shutdown
  output pdpm_pkg::pdpm_switch_s              switches_o         // power path enables
);
  import pdpm_pkg::*;

  // attach pin synchroniser
  logic        attach_meta_reg;  // first stage, read only by second
  logic        attach_sync_reg;  // second stage
  logic        attach_prev_reg;  // for edge detection
  logic        attach_rise;      // new attachment

  // state
  pdpm_state_e state_reg;        // power state
  pdpm_state_e state_next;       // next power state
  pdpm_boot_e  boot_reg;         // boot phase
  pdpm_boot_e  boot_next;        // next boot phase
  logic [PDPM_CNT_W-1:0] quiet_reg;   // quiet cycles seen
  logic [PDPM_CNT_W-1:0] quiet_next;  // next quiet count

  // decode
  logic        any_activity;     // any wake source
  logic        quiet_done;       // interval elapsed
  logic        die_trip;         // die shutdown from trip cell
  logic        path_a_trip;      // port a path over threshold
  logic        path_b_trip;      // port b path over threshold
  logic        path_trip;        // either path tripped
  logic        booted;           // configuration loaded
  pdpm_switch_s sw_next;         // switch enables next
  logic        run_gate;         // booted, cool and awake
  logic        standby_now;      // idle running as standby
  logic        src_allowed;      // source switches may close
  logic        sink_allowed;     // sink drivers may turn on
  logic        cable_allowed;    // cable supply may close
  logic [PDPM_CNT_W-1:0] quiet_gated;  // counter load, zero outside active

  // next values of the registered outputs
  logic        standby_next;     // idle with standby selected
  logic        func_next;        // non-supervisory logic allowed
  logic        fetch_next;       // boot still in eeprom phase
  logic        loaded_next;      // boot finished
  logic        wait_host_next;   // boot waits on the host

  // output flops
  logic [1:0]  state_code_reg;   // encoded state
  logic        standby_reg;      // standby flag
  logic        cc_mon_reg;       // cc monitor
  logic        func_reg;         // functions enable
  logic        die_sd_reg;       // die shutdown copy
  logic        path_sd_reg;      // path shutdown copy
  logic        fetch_reg;        // eeprom fetch request
  logic        loaded_reg;       // config loaded
  logic        wait_host_reg;    // waiting on host
  pdpm_switch_s sw_reg;          // switch enables
  logic [6:0]  addr_reg;         // eeprom target address

  // two-flop synchroniser and edge detect on the attach pin
  // the pin is asynchronous, so only the second stage feeds any logic
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      attach_meta_reg <= 1'b0;
      attach_sync_reg <= 1'b0;
      attach_prev_reg <= 1'b0;
    end else if (ce_i) begin
      attach_meta_reg <= cc_attach_i;
      attach_sync_reg <= attach_meta_reg;
      attach_prev_reg <= attach_sync_reg;
    end
  end
  assign attach_rise = attach_sync_reg & ~attach_prev_reg;

  // die trip: always auto-resumes once cooled
  // die shutdown never latches; cooling alone brings functions back
  pdpm_thermal_trip u_die_trip (
    .ref_clk_i  (ref_clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .temp_i     (die_temp_i),
    .thresh_i   (cfg_i.die_shutdown_threshold),
    .hyst_i     (cfg_i.die_shutdown_hysteresis),
    .auto_i     (1'b1),
    .reenable_i (1'b0),
    .trip_o     (die_trip)
  );

  // each path sensor trips on its own; either one opens the source and cable supply switches of both ports, sink drivers stay on
  pdpm_thermal_trip u_path_a_trip (
    .ref_clk_i  (ref_clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .temp_i     (path_a_temp_i),
    .thresh_i   (cfg_i.path_shutdown_threshold),
    .hyst_i     (cfg_i.path_shutdown_hysteresis),
    .auto_i     (cfg_i.path_auto_resume),
    .reenable_i (cfg_i.path_fw_reenable),
    .trip_o     (path_a_trip)
  );

  pdpm_thermal_trip u_path_b_trip (
    .ref_clk_i  (ref_clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .temp_i     (path_b_temp_i),
    .thresh_i   (cfg_i.path_shutdown_threshold),
    .hyst_i     (cfg_i.path_shutdown_hysteresis),
    .auto_i     (cfg_i.path_auto_resume),
    .reenable_i (cfg_i.path_fw_reenable),
    .trip_o     (path_b_trip)
  );

  // either sensor alone shuts both source paths and the cable supply
  assign path_trip = path_a_trip | path_b_trip;

  // activity and quiet-interval decode
  assign any_activity = activity_i.pd_msg | activity_i.cc_change | activity_i.gpio_evt |
                        activity_i.i2c_xact | activity_i.volt_alert | activity_i.fault_alert |
                        attach_rise;
  // the count saturates at the interval instead of wrapping
  assign quiet_done   = (quiet_reg >= cfg_i.idle_interval);
  assign quiet_next   = any_activity ? PDPM_CNT_ZERO :
                        (quiet_done ? quiet_reg : quiet_reg + PDPM_CNT_ONE);
  assign booted       = (boot_reg == PDPM_BOOT_DONE);
  // the counter only runs in active, so every wake starts a fresh interval
  assign quiet_gated  = (state_reg == PDPM_ACTIVE) ? quiet_next : PDPM_CNT_ZERO;

  // boot sequencing: eeprom first, host load on no answer
  // boot ends at once when the eeprom fetch succeeds
  always_comb begin
    boot_next = boot_reg;
    case (boot_reg)
      PDPM_BOOT_EEPROM: begin
        // a host load overtakes a fetch still in progress
        if (host_load_done_i) begin
          boot_next = PDPM_BOOT_DONE;
        end else if (eeprom_done_i) begin
          boot_next = PDPM_BOOT_DONE;
        end else if (eeprom_nack_i) begin
          boot_next = PDPM_BOOT_WAIT_HOST;
        end
      end
      PDPM_BOOT_WAIT_HOST: begin
        // no eeprom answered; only the host can finish boot
        if (host_load_done_i) begin
          boot_next = PDPM_BOOT_DONE;
        end
      end
      PDPM_BOOT_DONE: begin
        // configuration stays until the next reset
        boot_next = PDPM_BOOT_DONE;
      end
      default: begin
        // unused code: restart boot
        boot_next = PDPM_BOOT_EEPROM;
      end
    endcase
  end

  // power state selection
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PDPM_ACTIVE: begin
        // interval elapsed with nothing new: drop to idle
        if (quiet_done && !any_activity) begin
          state_next = PDPM_IDLE;
        end
      end
      PDPM_IDLE: begin
        // activity wins over a pending sleep request
        if (any_activity) begin
          state_next = PDPM_ACTIVE;
        end else if (cfg_i.sleep_req) begin
          state_next = PDPM_SLEEP;
        end
      end
      PDPM_SLEEP: begin
        // only a wake source, such as a new attach, leaves sleep
        if (any_activity) begin
          state_next = PDPM_ACTIVE;
        end
      end
      default: begin
        // unused code: recover into active
        state_next = PDPM_ACTIVE;
      end
    endcase
  end

  // gating terms for the power path enables; sourcing wins over sinking
  assign run_gate      = booted && !die_trip && (state_reg != PDPM_SLEEP);
  assign standby_now   = (state_reg == PDPM_IDLE) && cfg_i.standby_en;
  assign src_allowed   = cfg_i.sourcing & ~path_trip;
  assign sink_allowed  = cfg_i.sinking & ~cfg_i.sourcing;
  assign cable_allowed = ~path_trip;

  // switch gating per state, role and thermal condition
  always_comb begin
    sw_next = PDPM_SW_OFF;
    if (run_gate) begin
      if (standby_now) begin
        // standby keeps only the port a source switch
        sw_next.port_a_source_switch = src_allowed;
      end else begin
        // full active or idle set for the present role
        sw_next.port_a_source_switch       = src_allowed;
        sw_next.port_b_source_switch       = src_allowed;
        sw_next.port_a_sink_gate_driver    = sink_allowed;
        sw_next.port_b_sink_gate_driver    = sink_allowed;
        sw_next.port_a_cable_supply_switch = cable_allowed;
        sw_next.port_b_cable_supply_switch = cable_allowed;
      end
    end
  end

  // state, boot and counter registers
  // reset enters active and restarts boot from the eeprom
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_reg <= PDPM_ACTIVE;
      boot_reg  <= PDPM_BOOT_EEPROM;
      quiet_reg <= PDPM_CNT_ZERO;
    end else if (ce_i) begin
      state_reg <= state_next;
      boot_reg  <= boot_next;
      quiet_reg <= quiet_gated;
    end
  end

  // output decodes, registered below
  assign standby_next   = (state_next == PDPM_IDLE) && cfg_i.standby_en;
  assign func_next      = ~die_trip;
  assign fetch_next     = (boot_next == PDPM_BOOT_EEPROM);
  assign loaded_next    = (boot_next == PDPM_BOOT_DONE);
  assign wait_host_next = (boot_next == PDPM_BOOT_WAIT_HOST);

  // registered outputs; the state code shows the state being entered
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin  // all off, address held
      state_code_reg <= PDPM_ACTIVE;
      standby_reg    <= 1'b0;
      cc_mon_reg     <= 1'b0;
      func_reg       <= 1'b0;
      die_sd_reg     <= 1'b0;
      path_sd_reg    <= 1'b0;
      fetch_reg      <= 1'b0;
      loaded_reg     <= 1'b0;
      wait_host_reg  <= 1'b0;
      sw_reg         <= PDPM_SW_OFF;
      addr_reg       <= PDPM_EEPROM_ADDR;
    end else if (ce_i) begin  // load the decoded next values
      state_code_reg <= state_next;
      standby_reg    <= standby_next;
      cc_mon_reg     <= 1'b1;
      func_reg       <= func_next;
      die_sd_reg     <= die_trip;
      path_sd_reg    <= path_trip;
      fetch_reg      <= fetch_next;
      loaded_reg     <= loaded_next;
      wait_host_reg  <= wait_host_next;
      sw_reg         <= sw_next;
      addr_reg       <= PDPM_EEPROM_ADDR;
    end
  end

  // top-level outputs come straight from the flops above
  assign power_state_o   = state_code_reg;
  assign standby_o       = standby_reg;
  assign cc_monitor_en_o = cc_mon_reg;
  assign functions_en_o  = func_reg;
  assign die_shutdown_o  = die_sd_reg;
  assign path_shutdown_o = path_sd_reg;
  assign eeprom_fetch_o  = fetch_reg;
  assign eeprom_addr_o   = addr_reg;
  assign config_loaded_o = loaded_reg;
  assign waiting_host_o  = wait_host_reg;
  assign switches_o      = sw_reg;
endmodule : pdpm_manager
`default_nettype wire

/* File: dv/pdpm_manager_monitor.sv */
// checker: port assertions for the power state and thermal manager
`timescale 1ns/10ps
`default_nettype none
module pdpm_manager_monitor
  import pdpm_pkg::*;
(
  input wire logic           ref_clk_i,        // clock
  input wire logic           srst_i,           // sync reset
  input wire logic           ce_i,             // clock enable
  input wire pdpm_activity_s activity_i,       // activity pulses
  input wire logic           cc_attach_i,      // attach pin
  input wire pdpm_cfg_s      cfg_i,            // configuration
  input wire logic [7:0]     die_temp_i,       // die temperature
  input wire logic [7:0]     path_a_temp_i,    // path a temperature
  input wire logic [7:0]     path_b_temp_i,    // path b temperature
  input wire logic           eeprom_done_i,    // fetch ok
  input wire logic           eeprom_nack_i,    // no eeprom
  input wire logic           host_load_done_i, // host load
  input wire logic           eeprom_fetch_o,   // fetch phase
  input wire logic [6:0]     eeprom_addr_o,    // eeprom address
  input wire logic           config_loaded_o,  // loaded
  input wire logic           waiting_host_o,   // waiting host
  input wire logic [1:0]     power_state_o,    // state code
  input wire logic           standby_o,        // standby flag
  input wire logic           cc_monitor_en_o,  // cc watch
  input wire logic           functions_en_o,   // functions on
  input wire logic           die_shutdown_o,   // die trip
  input wire logic           path_shutdown_o,  // path trip
  input wire pdpm_switch_s   switches_o        // switch enables
);
  // every check runs on the one clock and rests during reset
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  AST_ADDR: assert property (eeprom_addr_o == PDPM_EEPROM_ADDR) else $error("eeprom address wrong");
  AST_LEGAL: assert property (power_state_o != 2'h3) else $error("illegal state code");
  AST_SLEEP_OFF: assert property (power_state_o == 2'h2 && $past(power_state_o) == 2'h2 |-> switches_o == PDPM_SW_OFF)
    else $error("switch on in sleep");
  AST_UNLOADED: assert property (!config_loaded_o |-> switches_o == PDPM_SW_OFF) else $error("switch before load");
  AST_DIE_TRIP: assert property (ce_i && die_temp_i > cfg_i.die_shutdown_threshold [*2] |=> die_shutdown_o)
    else $error("die trip missed");
  AST_DIE_OFF: assert property (die_shutdown_o && $past(die_shutdown_o) |-> !functions_en_o && switches_o == PDPM_SW_OFF)
    else $error("function on in die shutdown");
  AST_PATH_OFF: assert property (path_shutdown_o && $past(path_shutdown_o) |-> !switches_o.port_a_source_switch
    && !switches_o.port_b_source_switch && !switches_o.port_a_cable_supply_switch && !switches_o.port_b_cable_supply_switch)
    else $error("path on in path shutdown");
  AST_SLEEP_CC: assert property (power_state_o == 2'h2 |-> cc_monitor_en_o) else $error("cc watch off in sleep");
  AST_STANDBY: assert property (standby_o |-> power_state_o == 2'h1) else $error("standby outside idle");
  AST_WAKE: assert property (power_state_o == 2'h1 && ce_i && activity_i != '0 && !cfg_i.sleep_req
    |-> ##[1:2] power_state_o == 2'h0) else $error("idle did not wake");
  AST_NACK: assert property (eeprom_fetch_o && eeprom_nack_i && ce_i && !host_load_done_i |-> ##[1:2] waiting_host_o)
    else $error("no wait after nack");
  // main scenarios reached
  COV_SLEEP: cover property (power_state_o == 2'h2);
  COV_DIE: cover property (die_shutdown_o);
  COV_STBY: cover property (standby_o);
endmodule : pdpm_manager_monitor
bind pdpm_manager pdpm_manager_monitor pdpm_manager_monitor_i (.ref_clk_i, .srst_i, .ce_i, .activity_i, .cc_attach_i,
  .cfg_i, .die_temp_i, .path_a_temp_i, .path_b_temp_i, .eeprom_done_i, .eeprom_nack_i, .host_load_done_i,
  .eeprom_fetch_o, .eeprom_addr_o, .config_loaded_o, .waiting_host_o, .power_state_o, .standby_o,
  .cc_monitor_en_o, .functions_en_o, .die_shutdown_o, .path_shutdown_o, .switches_o);
`default_nettype wire

/* File: dv/pdpm_ec_model.sv */
// model: eeprom and embedded controller answering the boot loader
`timescale 1ns/10ps
`default_nettype none
module pdpm_ec_model (
  input  wire logic       ref_clk_i,        // clock
  input  wire logic       fetch_i,          // eeprom fetch running
  input  wire logic       wait_i,           // device waits for host
  input  wire logic       present_i,        // eeprom fitted
  input  wire logic [3:0] delay_i,          // answer latency
  output var logic        eeprom_done_o,    // fetch ok pulse
  output var logic        eeprom_nack_o,    // no answer pulse
  output var logic        host_load_done_o  // host load pulse
);
  int   cnt = 0;    // cycles in current phase
  logic f_q = 1'b0; // last fetch level
  // answer once per phase after the latency; a phase change restarts it
  always @(posedge ref_clk_i) begin
    {eeprom_done_o, eeprom_nack_o, host_load_done_o} <= 3'h0;
    f_q <= fetch_i;
    cnt <= ((fetch_i || wait_i) && fetch_i == f_q) ? cnt + 1 : 0;
    if (fetch_i && cnt == delay_i) begin
      eeprom_done_o <= present_i;
      eeprom_nack_o <= !present_i;
    end
    if (wait_i && cnt == delay_i) host_load_done_o <= 1'b1;
  end
endmodule : pdpm_ec_model
`default_nettype wire

/* File: dv/pdpm_manager_tb.sv */
// testbench: boot, power states, switch gating and thermal trips
`timescale 1ns/10ps
`default_nettype none
module pdpm_manager_tb;
  import pdpm_pkg::*;
  logic           ref_clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, cc_att = 1'b0, present = 1'b0;
  pdpm_activity_s act = '0;                                 // activity pulses
  pdpm_cfg_s      cfg = '0;                                 // configuration
  logic [7:0]     die_t = 8'h20, pa_t = 8'h20, pb_t = 8'h20; // temperatures
  logic [3:0]     dly = 4'h9;                               // partner latency
  logic           done, nack, hld, fetch, waith, loaded, sb, ccm, fen, dsd, psd;
  logic [1:0]     st;                                       // state code
  logic [6:0]     addr;                                     // eeprom address
  pdpm_switch_s   sw;                                       // switch enables
  int             fail_count = 0, checked = 0, seed = 32'h77413dcd, n;
  // free running clock
  always #50 ref_clk_i = ~ref_clk_i;
  pdpm_manager pdpm_manager_i (.ref_clk_i, .srst_i, .ce_i, .activity_i(act), .cc_attach_i(cc_att), .cfg_i(cfg),
    .die_temp_i(die_t), .path_a_temp_i(pa_t), .path_b_temp_i(pb_t), .eeprom_done_i(done), .eeprom_nack_i(nack),
    .host_load_done_i(hld), .eeprom_fetch_o(fetch), .eeprom_addr_o(addr), .config_loaded_o(loaded),
    .waiting_host_o(waith), .power_state_o(st), .standby_o(sb), .cc_monitor_en_o(ccm), .functions_en_o(fen),
    .die_shutdown_o(dsd), .path_shutdown_o(psd), .switches_o(sw));
  pdpm_ec_model pdpm_ec_model_i (.ref_clk_i, .fetch_i(fetch), .wait_i(waith), .present_i(present), .delay_i(dly),
    .eeprom_done_o(done), .eeprom_nack_o(nack), .host_load_done_o(hld));
  // advance k edges, then step off the edge
  task automatic tick(input int k = 1);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask : tick
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // bounded wait for a level
  task automatic wait_lv(ref logic b, input logic v);
    for (n = 0; n < 60 && b !== v; n++) tick();
    chk(b, v);
  endtask : wait_lv
  // bench model of the switch enables for a state
  function automatic pdpm_switch_s exp_sw(input int s);
    if (s == 2) return PDPM_SW_OFF;
    if (s == 1 && cfg.standby_en) return cfg.sourcing ? 6'h20 : 6'h00;
    return cfg.sourcing ? 6'h33 : 6'h0f;
  endfunction : exp_sw
  // one activity pulse of a given source, then a quiet cycle
  task automatic poke(input int k);
    act = pdpm_activity_s'(6'h01 << k);
    tick();
    act = '0;
    tick();
  endtask : poke
  // wait for a state code and check its switch enables
  task automatic wait_st(input logic [1:0] s);
    for (n = 0; n < 60 && st !== s; n++) tick();
    chk(st, s);
    tick(2);
    chk(sw, exp_sw(s));
  endtask : wait_st
  // verdict
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // watchdog against a hang
  initial begin
    #(3000 * 100);
    fail_count++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    cfg.idle_interval = 16'h0005;
    cfg.die_shutdown_threshold = 8'h64;
    cfg.die_shutdown_hysteresis = 8'h0a;
    cfg.path_shutdown_threshold = 8'h50;
    cfg.path_shutdown_hysteresis = 8'h08;
    // boot without eeprom (slow host), then with eeprom (prompt)
    for (int p = 0; p < 2; p++) begin
      srst_i = 1'b1;
      present = p[0];
      dly = p ? 4'h1 : 4'h9;
      tick(20);
      chk(sw, PDPM_SW_OFF);
      chk(addr, 7'h50);
      srst_i = 1'b0;
      tick();
      chk(fetch, 1'b1);
      chk(st, 2'h0);
      if (p == 0) wait_lv(waith, 1'b1);
      wait_lv(loaded, 1'b1);
      chk(waith, 1'b0);
      chk(ccm, 1'b1);
    end
    // each role with and without standby: activity holds active, quiet leads to idle
    for (int r = 0; r < 4; r++) begin
      cfg.sourcing = r[0];
      cfg.sinking = !r[0];
      cfg.standby_en = r[1];
      repeat (10) poke($unsigned($random(seed)) % 6);
      chk(st, 2'h0);
      chk(sw, exp_sw(0));
      for (n = 0; n < 60 && st !== 2'h1; n++) tick();
      chk(n > 3 && n < 11, 1'b1);
      wait_st(2'h1);
      chk(sb, r[1]);
    end
    // frozen clock enable holds idle, then sleep, then attach wakes
    ce_i = 1'b0;
    cfg.sleep_req = 1'b1;
    tick(6);
    chk(st, 2'h1);
    ce_i = 1'b1;
    wait_st(2'h2);
    chk(ccm, 1'b1);
    cfg.sleep_req = 1'b0;
    cc_att = 1'b1;
    wait_st(2'h0);
    cc_att = 1'b0;
    // die overtemperature with hysteresis boundary
    die_t = 8'h65 + 8'($unsigned($random(seed)) % 32);
    wait_lv(dsd, 1'b1);
    tick(2);
    chk(fen, 1'b0);
    chk(sw, PDPM_SW_OFF);
    die_t = 8'h5a;
    tick(8);
    chk(dsd, 1'b1);
    die_t = 8'h59;
    wait_lv(dsd, 1'b0);
    tick(2);
    chk(fen, 1'b1);
    // path trips from each sensor, firmware re-enable then automatic resume
    for (int a = 0; a < 2; a++) begin
      cfg.path_auto_resume = a[0];
      pa_t = a ? 8'h20 : 8'h51;
      pb_t = a ? 8'h51 : 8'h20;
      wait_lv(psd, 1'b1);
      tick(2);
      chk(sw, PDPM_SW_OFF);
      pa_t = 8'h47;
      pb_t = 8'h47;
      if (a == 0) begin
        tick(8);
        chk(psd, 1'b1);
        cfg.path_fw_reenable = 1'b1;
        tick();
        cfg.path_fw_reenable = 1'b0;
      end
      wait_lv(psd, 1'b0);
    end
    tally_and_finish();
  end
endmodule : pdpm_manager_tb
`default_nettype wire
